// File: ofmux_pkg.sv
// Constants, condition indices and timing for the output terminal mux
package ofmux_pkg;

  // ----------------------------------------------------------------------
  // Terminals and selection codes
  // ----------------------------------------------------------------------
  localparam int            NTERM         = 3;
  localparam int            CODE_W        = 14;
  localparam logic [13:0]   CODE_INV_BASE = 14'h0064;  // 100, sink logic
  localparam logic [13:0]   CODE_TOP      = 14'h00C8;  // 200, past sink
  localparam logic [13:0]   CODE_NONE     = 14'h270F;  // 9999, no function
  localparam logic [13:0]   RESET_CODE    = 14'h270F;  // Spare default
  localparam logic [6:0]    BASE_NONE     = 7'h7F;

  // ----------------------------------------------------------------------
  // Condition indices into the condition vector
  // ----------------------------------------------------------------------
  localparam int C_SU    = 0;
  localparam int C_RDY   = 1;
  localparam int C_OCD   = 2;
  localparam int C_LPD   = 3;
  localparam int C_PLO   = 4;
  localparam int C_PHI   = 5;
  localparam int C_PFWD  = 6;
  localparam int C_BRK   = 7;
  localparam int C_FAN   = 8;
  localparam int C_FIN   = 9;
  localparam int C_PLD   = 10;
  localparam int C_PIDA  = 11;
  localparam int C_RETRY = 12;
  localparam int C_WEAR  = 13;
  localparam int C_HWF   = 14;
  localparam int C_PULSE = 15;
  localparam int C_SVC   = 16;
  localparam int C_REM   = 17;
  localparam int C_MINOR = 18;
  localparam int C_MAJOR = 19;
  localparam int NCOND   = 20;

  // Source-logic code of each condition, in index order
  localparam logic [6:0] CODE_TAB [NCOND] = '{
    7'h01, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h14, 7'h19, 7'h1A,
    7'h2E, 7'h2F, 7'h40, 7'h5A, 7'h5B, 7'h5D, 7'h5F, 7'h60, 7'h62, 7'h63};

  // ----------------------------------------------------------------------
  // Timing and scaling
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_NS         = 100_000;   // Duration time base 0.1 ms
  localparam int TICK_CYC        = (TICK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_NS = 2_560;     // One pulse-train frame
  localparam int PULSE_CYC       = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int HEAT_PCT        = 85;
  localparam int PCT_FULL        = 100;
  localparam logic RST_OUT       = 1'b0;

endpackage : ofmux_pkg

// File: ofmux_cond_if.sv
// Condition vector carried from the condition logic to the selectors
`timescale 1ns/1ps
`default_nettype none

interface ofmux_cond_if;
  logic [ofmux_pkg::NCOND-1:0] active;

  modport producer (output active);
  modport consumer (input active);
endinterface : ofmux_cond_if

`default_nettype wire

// File: ofmux_timer.sv
// Level qualifier: asserts once a level has held longer than a duration
`timescale 1ns/1ps
`default_nettype none

module ofmux_timer #(
  parameter int DUR_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Qualification
  input  wire logic             level,
  input  wire logic             tick,
  input  wire logic [DUR_W-1:0] dur,
  output var  logic             qual
);

  typedef struct packed {
    logic [DUR_W-1:0] cnt;
    logic             q;
  } ofmux_tmr_t;

  ofmux_tmr_t st_r;
  ofmux_tmr_t st_nxt;

  // Count ticks while the level holds, saturating at full scale
  always_comb
  begin
    st_nxt = st_r;
    if (!level)
    begin
      st_nxt.cnt = '0;
    end
    else if (tick && (st_r.cnt != {DUR_W{1'b1}}))
    begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
    // Strictly longer than the set time, never on a short glitch
    st_nxt.q = level && (st_nxt.cnt > dur);  // R5 R6
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign qual = st_r.q;

endmodule : ofmux_timer

`default_nettype wire

// File: ofmux_sel.sv
// Per-terminal selector: decodes a code and picks the condition level
`timescale 1ns/1ps
`default_nettype none

module ofmux_sel #(
  parameter bit ALLOW_PULSE = 1'b1
) (
  // Selection
  input  wire logic [13:0]   code,
  input  wire logic          remote,
  ofmux_cond_if.consumer     cif,
  // Result
  output var  logic          conduct,
  output var  logic          refused
);

  // Split code into base and sense, then look the base up
  always_comb
  begin
    logic [6:0] base;
    logic       inv;
    logic       hit;
    logic       act;
    base    = ofmux_pkg::BASE_NONE;
    inv     = 1'b0;
    hit     = 1'b0;
    act     = 1'b0;
    refused = 1'b0;
    if (code < ofmux_pkg::CODE_INV_BASE)
    begin
      base = code[6:0];
    end
    else if (code < ofmux_pkg::CODE_TOP)
    begin
      base = 7'(code - ofmux_pkg::CODE_INV_BASE);
      inv  = 1'b1;  // R2
    end
    for (int i = 0; i < ofmux_pkg::NCOND; i++)
    begin
      if (base == ofmux_pkg::CODE_TAB[i])
      begin
        hit = 1'b1;
        act = (i == ofmux_pkg::C_REM) ? remote : cif.active[i];  // R19
      end
    end
    // Pulse train would wear a relay contact; this terminal refuses it
    if (!ALLOW_PULSE && (base == ofmux_pkg::CODE_TAB[ofmux_pkg::C_PULSE]))
    begin
      hit     = 1'b0;  // R17
      refused = 1'b1;  // R17
    end
    conduct = hit && (act ^ inv);  // R2 R3
  end

endmodule : ofmux_sel

`default_nettype wire

// File: ofmux_top.sv
// Output terminal function mux: conditions, selectors and output flops
//
// What this block does
// R1 - Three terminals, each with own selection code
// R2 - Low codes conduct when active, high invert
// R3 - Same code on several terminals drives identically, save 96/196 (own remote bit) and 93/193 on the relay
// R4 - Code 11/111 reports ready or running
// R5 - Code 12/112: current above threshold too long
// R6 - Code 13/113: power below threshold too long
// R7 - Codes 14/15: loop feedback below/above limits
// R8 - Code 16/116: loop commands forward rotation
// R9 - Code 20/120: brake release only when enabled
// R10 - Code 25/125: cooling fan fault
// R11 - Code 26/126: heatsink at 85 percent of trip
// R12 - Code 46/146: power-loss decel latched until release
// R13 - Code 47/147: process-control mode active
// R14 - Code 64/164: retry in progress
// R15 - Code 90/190: any wear item near end
// R16 - Code 91/191: internal circuit or wiring fault
// R17 - Code 93/193 pulse train, refused on relay
// R18 - Code 95/195: service timer reached alarm value
// R19 - Code 96/196: follows remote output setting
// R20 - Code 98/198: fan failure or comms warning
// R21 - Code 99/199: trip fault, cleared by reset
// R22 - Reached indication steady with zero ramp times
// R23 - Keep toggling signals off the relay contact
`timescale 1ns/1ps
`default_nettype none

module ofmux_top #(
  parameter int TICK_CYC = ofmux_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // Terminal selection codes
  input  wire logic [13:0] TERM_CODE_OC1,
  input  wire logic [13:0] TERM_CODE_OC2,
  input  wire logic [13:0] TERM_CODE_RELAY,
  input  wire logic [2:0]  SOFTWARE_DRIVEN_OUTPUT,
  // Drive status
  input  wire logic        START_POSSIBLE,
  input  wire logic        RUNNING,
  input  wire logic        FREQ_AT_SETPOINT,
  input  wire logic        SETPOINT_CHANGING,
  input  wire logic        RAMP_TIMES_ZERO,
  // Current and power detection
  input  wire logic [9:0]  OUT_CURRENT,
  input  wire logic [9:0]  CURRENT_LIMIT,
  input  wire logic [15:0] CURRENT_TIME,
  input  wire logic [9:0]  OUT_POWER,
  input  wire logic [9:0]  POWER_LIMIT,
  input  wire logic [15:0] POWER_TIME,
  // Process-control loop
  input  wire logic        LOOP_ACTIVE,
  input  wire logic        LOOP_FORWARD,
  input  wire logic [9:0]  LOOP_FEEDBACK,
  input  wire logic [9:0]  LOOP_LOW_LIMIT,
  input  wire logic [9:0]  LOOP_HIGH_LIMIT,
  // Brake, cooling and power loss
  input  wire logic        BRAKE_SEQ_ENABLE,
  input  wire logic        BRAKE_RELEASE_REQ,
  input  wire logic        FAN_FAULT,
  input  wire logic [9:0]  HEATSINK_TEMP,
  input  wire logic [9:0]  HEATSINK_TRIP,
  input  wire logic        POWERLOSS_DECEL_START,
  input  wire logic        POWERLOSS_RELEASE,
  // Faults, retry and wear
  input  wire logic        RETRY_ACTIVE,
  input  wire logic [3:0]  WEAR_NEAR_END,
  input  wire logic        CIRCUIT_FAULT,
  input  wire logic        COMM_WARNING,
  input  wire logic        PROTECT_TRIP,
  input  wire logic        FAULT_RESET,
  // Maintenance and averaging
  input  wire logic [15:0] SERVICE_TIME,
  input  wire logic [15:0] SERVICE_ALARM,
  input  wire logic [9:0]  AVG_CURRENT,
  // Terminal drive, high means conducting, plus relay refusal and major fault flags
  output var  logic        OC1_CONDUCT,
  output var  logic        OC2_CONDUCT,
  output var  logic        RELAY_CONTACT_TERMINAL,
  output var  logic        RELAY_CODE_REFUSED,
  output var  logic        MAJOR_FAULT_OUT
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] tick_cnt;
    logic [7:0]  pcnt;
    logic        pphase;
    logic        pulse;
    logic        su;
    logic        pld;
    logic        hwf;
    logic        major;
    logic [2:0]  term;
    logic        refused;
  } ofmux_st_t;

  ofmux_st_t   st_r;
  ofmux_st_t   st_nxt;

  logic        tick;
  logic        ocd_q;
  logic        lpd_q;
  logic        heat_hot;
  logic [2:0]  sel_on;
  logic [2:0]  sel_ref;
  logic [13:0] codes [ofmux_pkg::NTERM];

  ofmux_cond_if cif ();

  assign tick = (st_r.tick_cnt == 16'(TICK_CYC - 1));
  assign codes[0] = TERM_CODE_OC1;
  assign codes[1] = TERM_CODE_OC2;
  assign codes[2] = TERM_CODE_RELAY;

  // ----------------------------------------------------------------------
  // Qualified level detectors
  // ----------------------------------------------------------------------
  // Durations count in ticks, so the set time sits in 0.1 ms steps
  ofmux_timer #(.DUR_W(16)) u_ocd (
    .clk     (CLK),
    .reset_n (RESET_N),
    .level   (OUT_CURRENT > CURRENT_LIMIT),  // R5
    .tick    (tick),
    .dur     (CURRENT_TIME),
    .qual    (ocd_q)
  );

  ofmux_timer #(.DUR_W(16)) u_lpd (
    .clk     (CLK),
    .reset_n (RESET_N),
    .level   (OUT_POWER < POWER_LIMIT),  // R6
    .tick    (tick),
    .dur     (POWER_TIME),
    .qual    (lpd_q)
  );

  // Integer compare avoids a divide for the 85 percent level
  assign heat_hot = (17'({7'h00, HEATSINK_TEMP}) * 17'(ofmux_pkg::PCT_FULL))
                 >= (17'({7'h00, HEATSINK_TRIP}) * 17'(ofmux_pkg::HEAT_PCT));

  // ----------------------------------------------------------------------
  // Condition vector
  // ----------------------------------------------------------------------
  assign cif.active[ofmux_pkg::C_SU]    = st_r.su;  // R22
  assign cif.active[ofmux_pkg::C_RDY]   = START_POSSIBLE || RUNNING;  // R4
  assign cif.active[ofmux_pkg::C_OCD]   = ocd_q;  // R5
  assign cif.active[ofmux_pkg::C_LPD]   = lpd_q;  // R6
  assign cif.active[ofmux_pkg::C_PLO]   = LOOP_FEEDBACK < LOOP_LOW_LIMIT;  // R7
  assign cif.active[ofmux_pkg::C_PHI]   = LOOP_FEEDBACK > LOOP_HIGH_LIMIT; // R7
  assign cif.active[ofmux_pkg::C_PFWD]  = LOOP_ACTIVE && LOOP_FORWARD;  // R8
  assign cif.active[ofmux_pkg::C_BRK]   = BRAKE_SEQ_ENABLE
                                          && BRAKE_RELEASE_REQ;  // R9
  assign cif.active[ofmux_pkg::C_FAN]   = FAN_FAULT;  // R10
  assign cif.active[ofmux_pkg::C_FIN]   = heat_hot;  // R11
  assign cif.active[ofmux_pkg::C_PLD]   = st_r.pld;  // R12
  assign cif.active[ofmux_pkg::C_PIDA]  = LOOP_ACTIVE;  // R13
  assign cif.active[ofmux_pkg::C_RETRY] = RETRY_ACTIVE;  // R14
  assign cif.active[ofmux_pkg::C_WEAR]  = |WEAR_NEAR_END;  // R15
  assign cif.active[ofmux_pkg::C_HWF]   = st_r.hwf;  // R16
  assign cif.active[ofmux_pkg::C_PULSE] = st_r.pulse;  // R17
  assign cif.active[ofmux_pkg::C_SVC]   = SERVICE_TIME >= SERVICE_ALARM; // R18
  assign cif.active[ofmux_pkg::C_REM]   = 1'b0;  // Per terminal instead
  assign cif.active[ofmux_pkg::C_MINOR] = FAN_FAULT || COMM_WARNING;  // R20
  assign cif.active[ofmux_pkg::C_MAJOR] = st_r.major;  // R21

  // ----------------------------------------------------------------------
  // Terminal selectors
  // ----------------------------------------------------------------------
  // One selector per terminal; the relay one refuses the pulse train
  generate
    for (genvar t = 0; t < ofmux_pkg::NTERM; t++)
    begin : g_term
      ofmux_sel #(.ALLOW_PULSE(t != 2)) u_sel (  // R1 R17
        .code    (codes[t]),
        .remote  (SOFTWARE_DRIVEN_OUTPUT[t]),  // R19
        .cif     (cif),
        .conduct (sel_on[t]),
        .refused (sel_ref[t])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // Duration time base
    st_nxt.tick_cnt = tick ? 16'h0000 : 16'(st_r.tick_cnt + 16'h0001);
    // Pulse frame alternates average current and service timer
    st_nxt.pcnt = 8'(st_r.pcnt + 8'h01);
    if (st_r.pcnt == 8'(ofmux_pkg::PULSE_CYC - 1))
    begin
      st_nxt.pcnt   = 8'h00;
      st_nxt.pphase = !st_r.pphase;
    end
    st_nxt.pulse = st_r.pphase ? (st_r.pcnt < SERVICE_TIME[15:8])
                               : (st_r.pcnt < AVG_CURRENT[9:2]);  // R17
    // With zero ramps a setpoint change must not chatter the indication
    st_nxt.su = FREQ_AT_SETPOINT
             || (RAMP_TIMES_ZERO && SETPOINT_CHANGING && st_r.su);  // R22
    // Latched flags; a new event wins over a clear in the same cycle
    if (POWERLOSS_RELEASE)
    begin
      st_nxt.pld = 1'b0;
    end
    if (POWERLOSS_DECEL_START)
    begin
      st_nxt.pld = 1'b1;  // R12
    end
    if (FAULT_RESET)
    begin
      st_nxt.major = 1'b0;  // R21
      st_nxt.hwf   = 1'b0;
    end
    if (PROTECT_TRIP)
    begin
      st_nxt.major = 1'b1;  // R21
    end
    if (CIRCUIT_FAULT)
    begin
      st_nxt.hwf = 1'b1;  // R16
    end
    // Terminal drive is registered so outputs come straight from flops
    st_nxt.term    = sel_on;  // R1 R3
    st_nxt.refused = sel_ref[2];  // R17
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign OC1_CONDUCT            = st_r.term[0];
  assign OC2_CONDUCT            = st_r.term[1];
  assign RELAY_CONTACT_TERMINAL = st_r.term[2];
  assign RELAY_CODE_REFUSED     = st_r.refused;
  assign MAJOR_FAULT_OUT        = st_r.major;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_ready_src;
    (TERM_CODE_OC1 == 14'h000B) && (START_POSSIBLE || RUNNING);
  endsequence

  sequence s_ready_sink;
    (TERM_CODE_OC2 == 14'h006F) && (START_POSSIBLE || RUNNING);
  endsequence

  sequence s_trip_then_hold;
    PROTECT_TRIP ##1 (!FAULT_RESET)[*2];
  endsequence

  ready_src_a: assert property (s_ready_src |=> OC1_CONDUCT)  // R4
    else $error("ready source code did not conduct");

  ready_sink_a: assert property (s_ready_sink |=> !OC2_CONDUCT)  // R2
    else $error("ready sink code conducted");

  same_code_a: assert property ((TERM_CODE_OC1 == TERM_CODE_OC2)  // R3
      && (SOFTWARE_DRIVEN_OUTPUT[0] == SOFTWARE_DRIVEN_OUTPUT[1])
      |=> (OC1_CONDUCT == OC2_CONDUCT))
    else $error("same code drove terminals differently");

  trip_hold_a: assert property (s_trip_then_hold |-> MAJOR_FAULT_OUT)  // R21
    else $error("major fault not held after trip");

  fault_clear_a: assert property (FAULT_RESET && !PROTECT_TRIP  // R21
      |=> !MAJOR_FAULT_OUT)
    else $error("major fault not cleared by reset");

  decel_latch_a: assert property (POWERLOSS_DECEL_START  // R12
      ##1 (!POWERLOSS_RELEASE)[*3] |-> cif.active[ofmux_pkg::C_PLD])
    else $error("power-loss flag dropped before release");

  relay_refuse_a: assert property ((TERM_CODE_RELAY == 14'h005D  // R17
      || TERM_CODE_RELAY == 14'h00C1)
      |=> (!RELAY_CONTACT_TERMINAL && RELAY_CODE_REFUSED))
    else $error("relay accepted pulse train code");

  brake_gate_a: assert property ((TERM_CODE_OC1 == 14'h0014)  // R9
      && !BRAKE_SEQ_ENABLE |=> !OC1_CONDUCT)
    else $error("brake request passed while disabled");

  svc_alarm_a: assert property ((TERM_CODE_OC1 == 14'h005F)  // R18
      && (SERVICE_TIME >= SERVICE_ALARM) |=> OC1_CONDUCT)
    else $error("service alarm not reported");

  wear_any_a: assert property ((TERM_CODE_OC2 == 14'h00BE)  // R15
      && (WEAR_NEAR_END != 4'h0) |=> !OC2_CONDUCT)
    else $error("inverted wear alarm conducted");

  remote_follow_a: assert property ((TERM_CODE_RELAY == 14'h0060)  // R19
      |=> (RELAY_CONTACT_TERMINAL == $past(SOFTWARE_DRIVEN_OUTPUT[2])))
    else $error("remote output not followed");

  // Pulse code excluded: the relay refuses it on purpose
  same_relay_a: assert property ((TERM_CODE_OC1 == TERM_CODE_RELAY)  // R3
      && (SOFTWARE_DRIVEN_OUTPUT[0] == SOFTWARE_DRIVEN_OUTPUT[2])
      && (TERM_CODE_OC1 != 14'h005D) && (TERM_CODE_OC1 != 14'h00C1)
      |=> (OC1_CONDUCT == RELAY_CONTACT_TERMINAL))
    else $error("same code drove relay differently");

  sequence s_reached_steady;
    RAMP_TIMES_ZERO && SETPOINT_CHANGING && cif.active[ofmux_pkg::C_SU];
  endsequence

  reached_hold_a: assert property (s_reached_steady  // R22
      |=> cif.active[ofmux_pkg::C_SU])
    else $error("reached indication chattered with zero ramps");

  minor_sink_a: assert property ((TERM_CODE_OC2 == 14'h00C6)  // R20
      && (FAN_FAULT || COMM_WARNING) |=> !OC2_CONDUCT)
    else $error("inverted minor fault conducted");

  hw_latch_a: assert property (CIRCUIT_FAULT  // R16
      |=> cif.active[ofmux_pkg::C_HWF])
    else $error("circuit fault not latched");

  no_func_a: assert property ((TERM_CODE_OC2 >= 14'h00C8)  // R2
      |=> !OC2_CONDUCT)
    else $error("no-function code conducted");

endmodule : ofmux_top

`default_nettype wire

// File: ofmux_load.sv
// Load model: external equipment wired to the three output terminals
`timescale 1ns/1ps
`default_nettype none

module ofmux_load (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Terminal levels, high means conducting
  input  wire logic [2:0]  conduct,
  // Contact wear indication
  output var  logic [15:0] relay_toggles
);
  logic relay_prev_r;

  // Count contact operations; frequent ones shorten contact life
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      relay_prev_r  <= 1'b0;
      relay_toggles <= 16'h0000;
    end
    else
    begin
      relay_prev_r <= conduct[2];
      if (conduct[2] != relay_prev_r)
        relay_toggles <= relay_toggles + 16'h0001;
    end
  end
endmodule : ofmux_load

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the output terminal function mux
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [13:0] code1 = 14'h270F, code2 = 14'h270F, code3 = 14'h270F;
  logic [2:0]  sw_out = 3'h0;
  logic        start_ok = 0, running = 0, at_set = 0, chg = 0, rz = 0;
  logic [9:0]  cur = 0, cur_lim = 0, pwr = 0, pwr_lim = 0;
  logic [15:0] cur_t = 0, pwr_t = 0;
  logic        lp_act = 0, lp_fwd = 0, brk_en = 0, brk_req = 0, fan = 0;
  logic [9:0]  fb = 0, fb_lo = 0, fb_hi = 0, hs = 0, hs_trip = 10'h03FF;
  logic        pl_start = 0, pl_rel = 0, retry = 0, circ = 0, comm = 0;
  logic        trip = 0, f_reset = 0;
  logic [3:0]  wear = 4'h0;
  logic [15:0] svc_t = 0, svc_al = 16'hFFFF;
  logic [9:0]  avg = 0;
  logic        oc1, oc2, relay, refused, major;
  logic [15:0] toggles;
  int          num_errors = 0;
  int          checked = 0;
  int          codes[18] = '{11, 12, 13, 14, 15, 16, 20, 25, 26, 46, 47, 64,
                             90, 91, 95, 96, 98, 99};
  int          cnt;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  ofmux_top #(.TICK_CYC(4)) ofmux_top_i (
    .CLK(clk), .RESET_N(reset_n), .TERM_CODE_OC1(code1),
    .TERM_CODE_OC2(code2), .TERM_CODE_RELAY(code3),
    .SOFTWARE_DRIVEN_OUTPUT(sw_out), .START_POSSIBLE(start_ok),
    .RUNNING(running), .FREQ_AT_SETPOINT(at_set),
    .SETPOINT_CHANGING(chg), .RAMP_TIMES_ZERO(rz), .OUT_CURRENT(cur),
    .CURRENT_LIMIT(cur_lim), .CURRENT_TIME(cur_t), .OUT_POWER(pwr),
    .POWER_LIMIT(pwr_lim), .POWER_TIME(pwr_t), .LOOP_ACTIVE(lp_act),
    .LOOP_FORWARD(lp_fwd), .LOOP_FEEDBACK(fb), .LOOP_LOW_LIMIT(fb_lo),
    .LOOP_HIGH_LIMIT(fb_hi), .BRAKE_SEQ_ENABLE(brk_en),
    .BRAKE_RELEASE_REQ(brk_req), .FAN_FAULT(fan), .HEATSINK_TEMP(hs),
    .HEATSINK_TRIP(hs_trip), .POWERLOSS_DECEL_START(pl_start),
    .POWERLOSS_RELEASE(pl_rel), .RETRY_ACTIVE(retry),
    .WEAR_NEAR_END(wear), .CIRCUIT_FAULT(circ), .COMM_WARNING(comm),
    .PROTECT_TRIP(trip), .FAULT_RESET(f_reset), .SERVICE_TIME(svc_t),
    .SERVICE_ALARM(svc_al), .AVG_CURRENT(avg), .OC1_CONDUCT(oc1),
    .OC2_CONDUCT(oc2), .RELAY_CONTACT_TERMINAL(relay),
    .RELAY_CODE_REFUSED(refused), .MAJOR_FAULT_OUT(major));

  ofmux_load ofmux_load_i (
    .clk(clk), .reset_n(reset_n), .conduct({relay, oc2, oc1}),
    .relay_toggles(toggles));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Expected terminal level from code and condition
  function automatic logic term_exp(input int code, input logic act);
    if (code < 100)
      return act;
    return (code < 200) ? !act : 1'b0;
  endfunction : term_exp

  // Temperature just under the prewarning level
  function automatic logic [9:0] cold(input logic [9:0] t);
    return 10'((int'(t) * 85 - 1) / 100);
  endfunction : cold

  task automatic check(input logic got, input logic exp, input string w);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: %s got %b exp %b", $time, w, got, exp);
    end
  endtask : check

  // Let n edges land, then sample 1 ns after the last
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Drive one condition on or off; boundary values for compares
  task automatic drive(input int code, input logic on);
    logic [9:0] v;
    logic       r;
    v = 10'($urandom_range(1000, 1));
    r = 1'($urandom);
    @(posedge clk);
    case (code)
      11: begin start_ok <= on & r; running <= on & !r; end
      12: begin cur_lim <= v; cur <= on ? v + 10'd1 : v; cur_t <= 16'h2; end
      13: begin pwr_lim <= v; pwr <= on ? v - 10'd1 : v; pwr_t <= 16'h2; end
      14: begin fb_lo <= v; fb_hi <= 10'h3FF; fb <= on ? v - 10'd1 : v; end
      15: begin fb_hi <= v; fb_lo <= 10'h000; fb <= on ? v + 10'd1 : v; end
      16: begin lp_act <= on; lp_fwd <= on; end
      20: begin brk_en <= on; brk_req <= 1'b1; end
      25: fan <= on;
      26: begin hs_trip <= v; hs <= on ? v : cold(v); end
      46: begin pl_start <= on; pl_rel <= !on; end
      47: lp_act <= on;
      64: retry <= on;
      90: wear <= on ? 4'($urandom_range(15, 1)) : 4'h0;
      91: begin circ <= on; f_reset <= !on; end
      95: begin svc_al <= 16'(v); svc_t <= on ? 16'(v) : 16'(v - 10'd1); end
      96: sw_out <= on ? 3'h7 : 3'h0;
      98: begin fan <= on & r; comm <= on & !r; end
      99: begin trip <= on; f_reset <= !on; end
      default: ;
    endcase
    // Latched events are one-cycle pulses so the hold is seen
    if (on && (code == 46 || code == 91 || code == 99))
    begin
      @(posedge clk);
      pl_start <= 1'b0;
      circ     <= 1'b0;
      trip     <= 1'b0;
    end
  endtask : drive

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Bound on the whole run
  initial
  begin
    #200us;
    num_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hab3b));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // Every code but 1 and 93, twice: plain on OC1 and relay, inverted on OC2
    for (int p = 0; p < 2; p++)
      foreach (codes[i])
      begin
        @(posedge clk);
        code1 <= 14'(codes[i]);
        code2 <= 14'(codes[i] + 100);
        code3 <= 14'(codes[i]);
        for (int on = 1; on >= 0; on--)
        begin
          drive(codes[i], 1'(on));
          settle(24);
          check(oc1, term_exp(codes[i], 1'(on)), "oc1");
          check(oc2, term_exp(codes[i] + 100, 1'(on)), "oc2");
          check(relay, term_exp(codes[i], 1'(on)), "relay");
          check(major, 1'(codes[i] == 99 && on == 1), "major");
        end
      end
    check(1'(toggles == 16'd72), 1'b1, "relay operations");
    // Pulse train on OC1, refused on the relay
    @(posedge clk);
    avg   <= 10'($urandom_range(1023));
    svc_t <= 16'($urandom);
    code1 <= 14'd93;
    code2 <= 14'h270F;
    code3 <= 14'd193;
    settle(4);
    cnt = 0;
    repeat (512)
    begin
      cnt += int'(oc1);
      settle(1);
    end
    check(1'(cnt == int'(avg[9:2]) + int'(svc_t[15:8])), 1'b1, "pulse");
    check(refused, 1'b1, "refused");
    check(relay, 1'b0, "relay 193");
    check(oc2, 1'b0, "no function");
    // Reached indication holds with zero ramp times
    @(posedge clk);
    code1  <= 14'd1;
    code3  <= 14'h270F;
    rz     <= 1'b1;
    chg    <= 1'b1;
    at_set <= 1'b1;
    settle(4);
    check(oc1, 1'b1, "reached");
    check(refused, 1'b0, "refusal released");
    @(posedge clk);
    at_set <= 1'b0;
    settle(4);
    check(oc1, 1'b1, "reached steady");
    // Trip, then a device reset clears the major fault
    drive(99, 1'b1);
    settle(4);
    check(major, 1'b1, "major set");
    @(posedge clk);
    reset_n <= 1'b0;
    #1;
    check(major, 1'b0, "major reset");
    settle(2);
    finish_test();
  end
endmodule : testbench

`default_nettype wire
